// ===== zbu_pkg.sv
// Package holding the constants, operation codes and carrier types of the zero-compare branch unit.
package zbu_pkg;

  // ----------------------------------------------------------------------
  // Widths, register numbers, offsets and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned ZBU_REGISTER_WIDTH = 32;
  localparam int unsigned ZBU_IMM_WIDTH = 16;
  localparam int unsigned ZBU_IMM_SHIFT = 2;
  localparam logic [4:0] ZBU_LINK_REG = 5'h1f;
  localparam logic [4:0] ZBU_ZERO_REG = 5'h00;
  localparam logic [31:0] ZBU_SLOT_OFFSET = 32'h0000_0004;
  localparam logic [31:0] ZBU_LINK_OFFSET = 32'h0000_0008;
  localparam logic [31:0] ZBU_ADDR_RESET = 32'h0000_0000;
  localparam logic ZBU_FLAG_RESET = 1'b0;

  // ----------------------------------------------------------------------
  // Operation classes presented by the decode stage
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ZBU_OP_NONE,
    ZBU_OP_BRANCH_LE_ZERO,
    ZBU_OP_BRANCH_LE_ZERO_LIKELY,
    ZBU_OP_BRANCH_LT_ZERO,
    ZBU_OP_BRANCH_LT_ZERO_LINK,
    ZBU_OP_BRANCH_LT_ZERO_LINK_LIKELY,
    ZBU_OP_OTHER_BRANCH,
    ZBU_OP_JUMP,
    ZBU_OP_UNCONDITIONAL_LINK_NO_JUMP,
    ZBU_OP_EXCEPTION_RETURN,
    ZBU_OP_EXCEPTION_RETURN_NOCLEAR,
    ZBU_OP_DEBUG_RETURN,
    ZBU_OP_WAIT,
    ZBU_OP_PAUSE
  } zbu_op_t;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    zbu_op_t op;
    logic [4:0] source_reg_field;
    logic [ZBU_REGISTER_WIDTH-1:0] source_value;
    logic [ZBU_IMM_WIDTH-1:0] offset;
    logic [ZBU_REGISTER_WIDTH-1:0] pc;
  } zbu_instr_t;

  typedef struct packed {
    logic valid;
    logic [ZBU_REGISTER_WIDTH-1:0] target;
  } zbu_redirect_t;

  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [ZBU_REGISTER_WIDTH-1:0] data;
  } zbu_link_t;

endpackage : zbu_pkg

// ===== zbu_cond_eval.sv
// Condition, target and link address evaluation for one zero-compare branch.
`timescale 1ns/1ps
`default_nettype none

module zbu_cond_eval (
  input wire logic le_form,
  input wire logic [zbu_pkg::ZBU_REGISTER_WIDTH-1:0] source_value,
  input wire logic [zbu_pkg::ZBU_IMM_WIDTH-1:0] offset,
  input wire logic [zbu_pkg::ZBU_REGISTER_WIDTH-1:0] pc,
  output logic cond,
  output logic [zbu_pkg::ZBU_REGISTER_WIDTH-1:0] target,
  output logic [zbu_pkg::ZBU_REGISTER_WIDTH-1:0] link_addr
);

  // ----------------------------------------------------------------------
  // Evaluation
  // ----------------------------------------------------------------------
  wire logic sign_bit = source_value[zbu_pkg::ZBU_REGISTER_WIDTH-1];
  wire logic is_zero = (source_value == '0);
  wire logic [zbu_pkg::ZBU_REGISTER_WIDTH-1:0] offset_ext;

  // The shifted offset is 18 bits wide and sign-extends to the full width.
  assign offset_ext = {{(zbu_pkg::ZBU_REGISTER_WIDTH - zbu_pkg::ZBU_IMM_WIDTH
                         - zbu_pkg::ZBU_IMM_SHIFT){offset[zbu_pkg::ZBU_IMM_WIDTH-1]}},
                       offset, {zbu_pkg::ZBU_IMM_SHIFT{1'b0}}}; // see RL1
  assign cond = le_form ? (sign_bit | is_zero) : sign_bit; // see RL2 see RL3
  assign target = pc + zbu_pkg::ZBU_SLOT_OFFSET + offset_ext; // see RL1
  assign link_addr = pc + zbu_pkg::ZBU_LINK_OFFSET; // see RL10

endmodule : zbu_cond_eval

`default_nettype wire

// ===== zbu_branch_unit.sv
// Zero-compare branch unit: condition, link, delay slot, nullification and slot checks.
// Summary of operation
// RL1 - Target is sign-extended offset shifted by two, added to delay-slot address.
// RL2 - Less-or-equal forms take the branch when sign set or value zero.
// RL3 - Less-than forms, link forms included, take the branch when sign bit set.
// RL4 - Condition and link in branch step; redirect after delay-slot step.
// RL5 - Non-likely forms always run the slot, then branch if condition holds.
// RL6 - Likely forms squash the delay-slot instruction when the condition is false.
// RL7 - Newest release raises reserved-instruction exception for transfers in a slot.
// RL8 - Branches, jumps, link-no-jump, returns, wait and pause count as transfers.
// RL9 - Older-release software keeps transfer instructions out of delay slots.
// RL10 - Link forms always write register 31 with branch address plus eight.
// RL11 - Software never tests register 31 in a link-form branch.
// RL12 - Slot exceptions resume by re-running the branch with the same effect.
// RL13 - Newest release rejects likely and link forms, keeps zero-source link-no-jump.
// RL14 - Likely forms predicted taken, prediction tables neither read nor updated.
// RL15 - A delay-slot flag marks only the instruction right after a branch or jump.
`timescale 1ns/1ps
`default_nettype none

module zbu_branch_unit (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic release6_mode,
  input wire logic pipe_flush,
  input wire zbu_pkg::zbu_instr_t instr,
  output zbu_pkg::zbu_link_t link_wr,
  output zbu_pkg::zbu_redirect_t redirect,
  output logic squash_slot_op,
  output logic reserved_instr_exc,
  output logic delay_slot_flag,
  output logic predict_taken,
  output logic bp_update_en
);

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic is_control_transfer_op(input zbu_pkg::zbu_op_t op);
    case (op)
      zbu_pkg::ZBU_OP_BRANCH_LE_ZERO,
      zbu_pkg::ZBU_OP_BRANCH_LE_ZERO_LIKELY,
      zbu_pkg::ZBU_OP_BRANCH_LT_ZERO,
      zbu_pkg::ZBU_OP_BRANCH_LT_ZERO_LINK,
      zbu_pkg::ZBU_OP_BRANCH_LT_ZERO_LINK_LIKELY,
      zbu_pkg::ZBU_OP_OTHER_BRANCH,
      zbu_pkg::ZBU_OP_JUMP,
      zbu_pkg::ZBU_OP_UNCONDITIONAL_LINK_NO_JUMP,
      zbu_pkg::ZBU_OP_EXCEPTION_RETURN,
      zbu_pkg::ZBU_OP_EXCEPTION_RETURN_NOCLEAR,
      zbu_pkg::ZBU_OP_DEBUG_RETURN,
      zbu_pkg::ZBU_OP_WAIT,
      zbu_pkg::ZBU_OP_PAUSE: is_control_transfer_op = 1'b1; // see RL8
      default: is_control_transfer_op = 1'b0;
    endcase
  endfunction : is_control_transfer_op

  function automatic logic opens_slot(input zbu_pkg::zbu_op_t op);
    case (op)
      zbu_pkg::ZBU_OP_BRANCH_LE_ZERO,
      zbu_pkg::ZBU_OP_BRANCH_LE_ZERO_LIKELY,
      zbu_pkg::ZBU_OP_BRANCH_LT_ZERO,
      zbu_pkg::ZBU_OP_BRANCH_LT_ZERO_LINK,
      zbu_pkg::ZBU_OP_BRANCH_LT_ZERO_LINK_LIKELY,
      zbu_pkg::ZBU_OP_OTHER_BRANCH,
      zbu_pkg::ZBU_OP_JUMP,
      zbu_pkg::ZBU_OP_UNCONDITIONAL_LINK_NO_JUMP: opens_slot = 1'b1;
      default: opens_slot = 1'b0;
    endcase
  endfunction : opens_slot

  function automatic logic is_likely(input zbu_pkg::zbu_op_t op);
    is_likely = (op == zbu_pkg::ZBU_OP_BRANCH_LE_ZERO_LIKELY) ||
                (op == zbu_pkg::ZBU_OP_BRANCH_LT_ZERO_LINK_LIKELY);
  endfunction : is_likely

  // ----------------------------------------------------------------------
  // Branch step decode
  // ----------------------------------------------------------------------
  wire logic vld = instr.valid & ~pipe_flush;
  wire logic op_le = (instr.op == zbu_pkg::ZBU_OP_BRANCH_LE_ZERO) ||
                     (instr.op == zbu_pkg::ZBU_OP_BRANCH_LE_ZERO_LIKELY);
  wire logic op_lt = (instr.op == zbu_pkg::ZBU_OP_BRANCH_LT_ZERO);
  wire logic op_link = (instr.op == zbu_pkg::ZBU_OP_BRANCH_LT_ZERO_LINK) ||
                       (instr.op == zbu_pkg::ZBU_OP_BRANCH_LT_ZERO_LINK_LIKELY);
  wire logic op_likely = is_likely(instr.op);
  wire logic src_is_zero = (instr.source_reg_field == zbu_pkg::ZBU_ZERO_REG);
  wire logic op_plain_link = (instr.op == zbu_pkg::ZBU_OP_BRANCH_LT_ZERO_LINK);
  wire logic op_nal = (instr.op == zbu_pkg::ZBU_OP_UNCONDITIONAL_LINK_NO_JUMP) ||
                      (release6_mode & op_plain_link & src_is_zero); // see RL13
  wire logic r6_removed = release6_mode & (op_likely | (op_plain_link & ~src_is_zero)); // see RL13
  wire logic own_branch = (op_le | op_lt | op_link) & ~r6_removed & ~op_nal;
  wire logic cond;
  wire logic [zbu_pkg::ZBU_REGISTER_WIDTH-1:0] target;
  wire logic [zbu_pkg::ZBU_REGISTER_WIDTH-1:0] link_addr;

  zbu_cond_eval u_eval (
    .le_form(op_le),
    .source_value(instr.source_value),
    .offset(instr.offset),
    .pc(instr.pc),
    .cond(cond),
    .target(target),
    .link_addr(link_addr)
  );

  // ----------------------------------------------------------------------
  // Pending branch state, held from the branch step to the slot step
  // ----------------------------------------------------------------------
  logic slot_q, slot_d;
  logic own_q, own_d;
  logic cond_q, cond_d;
  logic likely_q, likely_d;
  logic [zbu_pkg::ZBU_REGISTER_WIDTH-1:0] target_q, target_d;

  wire logic in_slot = vld & slot_q; // see RL15
  wire logic slot_cti = in_slot & is_control_transfer_op(instr.op);
  wire logic slot_exc = release6_mode & slot_cti; // see RL7
  // A branch in a slot is either an exception or unpredictable, so it opens no new slot.
  wire logic starts_branch = vld & ~in_slot & ~r6_removed;

  // A slot that faults leaves the redirect undone; the handler re-runs the branch.
  assign slot_d = starts_branch & opens_slot(instr.op) ? 1'b1 :
                  (vld ? 1'b0 : slot_q & ~pipe_flush); // see RL15 see RL12
  assign own_d = starts_branch ? own_branch : own_q;
  assign cond_d = starts_branch ? cond : cond_q;
  assign likely_d = starts_branch ? op_likely : likely_q;
  assign target_d = starts_branch ? target : target_q;

  // ----------------------------------------------------------------------
  // Output next values
  // ----------------------------------------------------------------------
  zbu_pkg::zbu_link_t link_d;
  zbu_pkg::zbu_redirect_t redirect_d;
  logic squash_d, exc_d, flag_d, pred_d, bpu_d;

  assign link_d.we = starts_branch & (op_link | op_nal); // see RL10 see RL4
  assign link_d.addr = zbu_pkg::ZBU_LINK_REG; // see RL10
  assign link_d.data = link_addr; // see RL10
  assign redirect_d.valid = in_slot & own_q & cond_q & ~slot_exc; // see RL4 see RL5
  assign redirect_d.target = target_q; // see RL4
  assign squash_d = in_slot & own_q & likely_q & ~cond_q & ~slot_exc; // see RL6
  assign exc_d = slot_exc | (vld & r6_removed); // see RL7 see RL13
  assign flag_d = in_slot; // see RL15
  assign pred_d = starts_branch & own_branch & op_likely; // see RL14
  assign bpu_d = starts_branch & own_branch & ~op_likely; // see RL14

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Reset clears the pending slot too, so a branch cut by reset never redirects.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slot_q <= zbu_pkg::ZBU_FLAG_RESET;
      own_q <= zbu_pkg::ZBU_FLAG_RESET;
      cond_q <= zbu_pkg::ZBU_FLAG_RESET;
      likely_q <= zbu_pkg::ZBU_FLAG_RESET;
    end else begin
      slot_q <= slot_d;
      own_q <= own_d;
      cond_q <= cond_d;
      likely_q <= likely_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      target_q <= zbu_pkg::ZBU_ADDR_RESET;
    end else begin
      target_q <= target_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link_wr <= '0;
    end else begin
      link_wr <= link_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      redirect <= '0;
    end else begin
      redirect <= redirect_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      squash_slot_op <= zbu_pkg::ZBU_FLAG_RESET;
    end else begin
      squash_slot_op <= squash_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reserved_instr_exc <= zbu_pkg::ZBU_FLAG_RESET;
    end else begin
      reserved_instr_exc <= exc_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      delay_slot_flag <= zbu_pkg::ZBU_FLAG_RESET;
    end else begin
      delay_slot_flag <= flag_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      predict_taken <= zbu_pkg::ZBU_FLAG_RESET;
      bp_update_en <= zbu_pkg::ZBU_FLAG_RESET;
    end else begin
      predict_taken <= pred_d;
      bp_update_en <= bpu_d;
    end
  end

endmodule : zbu_branch_unit

`default_nettype wire

// ===== zbu_branch_unit_properties.sv
// Checker watching the ports of the zero-compare branch unit.
`timescale 1ns/1ps
`default_nettype none
module zbu_branch_unit_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic release6_mode,
  input wire logic pipe_flush,
  input wire zbu_pkg::zbu_instr_t instr,
  input wire zbu_pkg::zbu_link_t link_wr,
  input wire zbu_pkg::zbu_redirect_t redirect,
  input wire logic squash_slot_op,
  input wire logic reserved_instr_exc,
  input wire logic delay_slot_flag,
  input wire logic predict_taken,
  input wire logic bp_update_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic take = instr.valid && !pipe_flush;
  wire logic likely_op = instr.op == zbu_pkg::ZBU_OP_BRANCH_LE_ZERO_LIKELY ||
                         instr.op == zbu_pkg::ZBU_OP_BRANCH_LT_ZERO_LINK_LIKELY;
  wire logic [31:0] tgt_calc = instr.pc + zbu_pkg::ZBU_SLOT_OFFSET +
                               {{14{instr.offset[15]}}, instr.offset, 2'b00};
  sequence s_taken_lt;
    take && instr.op == zbu_pkg::ZBU_OP_BRANCH_LT_ZERO && instr.source_value[31] && !release6_mode;
  endsequence
  sequence s_plain_slot;
    take && instr.op == zbu_pkg::ZBU_OP_NONE;
  endsequence
  a_quiet_after_reset: assert property ($fell(sys_rst) |-> !(link_wr.we ||
    redirect.valid || squash_slot_op || reserved_instr_exc || delay_slot_flag ||
    predict_taken || bp_update_en)) else $error("output active at first edge after reset");
  a_target_form: assert property (s_taken_lt ##1 s_plain_slot |=> redirect.valid &&
    redirect.target == $past(tgt_calc, 2)) else $error("redirect target wrong");
  a_link_addr_data: assert property (link_wr.we |-> link_wr.addr == zbu_pkg::ZBU_LINK_REG &&
    link_wr.data == $past(instr.pc) + zbu_pkg::ZBU_LINK_OFFSET) else $error("link write wrong");
  a_redirect_in_slot: assert property (redirect.valid |-> delay_slot_flag &&
    !squash_slot_op && !reserved_instr_exc) else $error("redirect outside a slot");
  a_redirect_single: assert property (redirect.valid |=> !redirect.valid)
    else $error("redirect lasted two cycles");
  a_likely_newest_exc: assert property (take && likely_op && release6_mode |=>
    reserved_instr_exc && !link_wr.we && !predict_taken) else $error("likely form accepted");
  a_exc_newest_only: assert property (reserved_instr_exc |-> $past(release6_mode) &&
    $past(take)) else $error("exception without newest release");
  a_predict_likely: assert property (predict_taken |-> $past(likely_op) && !bp_update_en)
    else $error("prediction flag wrong");
  a_squash_slot: assert property (squash_slot_op |-> delay_slot_flag && $past(take))
    else $error("squash outside a slot");
endmodule : zbu_branch_unit_checker
bind zbu_branch_unit zbu_branch_unit_checker u_chk (.clk, .sys_rst, .release6_mode, .pipe_flush,
  .instr, .link_wr, .redirect, .squash_slot_op, .reserved_instr_exc, .delay_slot_flag,
  .predict_taken, .bp_update_en);
`default_nettype wire

// ===== zbu_decode_model.sv
// Decode stage model presenting instructions to the branch unit.
`timescale 1ns/1ps
`default_nettype none
module zbu_decode_model (
  input wire logic clk,
  output var zbu_pkg::zbu_instr_t instr
);
  initial instr = '0;
  // Software here never tests register 31 in a link form, nor puts a transfer in an
  // older-release slot, since the outcome would be unpredictable.
  task automatic put(zbu_pkg::zbu_op_t op, logic [4:0] rs, logic [31:0] v, logic [31:0] pc);
    @(negedge clk);
    instr <= {1'b1, op, rs, v, 16'h8000, pc};
  endtask : put
  // Idle fields are inverted so stale data never looks valid.
  task automatic idle();
    @(negedge clk);
    instr <= {1'b0, zbu_pkg::ZBU_OP_NONE, ~instr.source_reg_field, ~instr.source_value,
              ~instr.offset, ~instr.pc};
  endtask : idle
endmodule : zbu_decode_model
`default_nettype wire

// ===== tb_zero_compare_branch_unit.sv
// Self-checking testbench of the zero-compare branch unit.
`timescale 1ns/1ps
`default_nettype none
module tb_zero_compare_branch_unit;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic release6_mode = 1'b0;
  logic pipe_flush = 1'b0;
  zbu_pkg::zbu_instr_t instr;
  zbu_pkg::zbu_link_t link_wr;
  zbu_pkg::zbu_redirect_t redirect;
  logic squash_slot_op, reserved_instr_exc, delay_slot_flag, predict_taken, bp_update_en;
  int n_errors = 0;
  int check_count = 0;
  initial forever #12.5 clk = ~clk;
  zbu_decode_model dec (.clk, .instr);
  zbu_branch_unit dut (.clk, .sys_rst, .release6_mode, .pipe_flush, .instr, .link_wr, .redirect,
    .squash_slot_op, .reserved_instr_exc, .delay_slot_flag, .predict_taken, .bp_update_en);
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Branch at 0x40000 with the most negative offset, then its slot.
  task automatic pair(zbu_pkg::zbu_op_t op, logic [4:0] rs, logic [31:0] v,
                      zbu_pkg::zbu_op_t slot, logic [2:0] e1, logic [2:0] e2);
    dec.put(op, rs, v, 32'h0004_0000);
    dec.put(slot, 5'h03, 32'h0000_0000, 32'h0004_0004);
    chk("link_exc_pred", {link_wr.we, reserved_instr_exc, predict_taken}, e1);
    if (e1[2]) chk("link_data", link_wr.data, 32'h0004_0008);
    dec.idle();
    chk("redir_squash_exc", {redirect.valid, squash_slot_op, reserved_instr_exc}, e2);
    if (e2[2]) chk("target", redirect.target, 32'h0002_0004);
  endtask : pair
  task automatic s_link();
    pair(zbu_pkg::ZBU_OP_BRANCH_LT_ZERO_LINK, 5'h02, 32'h8000_0000, zbu_pkg::ZBU_OP_NONE,
         3'b100, 3'b100);
    pair(zbu_pkg::ZBU_OP_BRANCH_LT_ZERO_LINK, 5'h02, 32'h0000_0000, zbu_pkg::ZBU_OP_NONE,
         3'b100, 3'b000);
  endtask : s_link
  task automatic s_conditions();
    pair(zbu_pkg::ZBU_OP_BRANCH_LE_ZERO, 5'h02, 32'h0, zbu_pkg::ZBU_OP_NONE, 3'b000, 3'b100);
    pair(zbu_pkg::ZBU_OP_BRANCH_LE_ZERO, 5'h02, 32'h1, zbu_pkg::ZBU_OP_NONE, 3'b000, 3'b000);
    pair(zbu_pkg::ZBU_OP_BRANCH_LT_ZERO, 5'h02, 32'h0, zbu_pkg::ZBU_OP_NONE, 3'b000, 3'b000);
    pair(zbu_pkg::ZBU_OP_BRANCH_LT_ZERO, 5'h02, 32'hffff_ffff, zbu_pkg::ZBU_OP_NONE,
         3'b000, 3'b100);
  endtask : s_conditions
  task automatic s_likely();
    pair(zbu_pkg::ZBU_OP_BRANCH_LE_ZERO_LIKELY, 5'h02, 32'h1, zbu_pkg::ZBU_OP_NONE,
         3'b001, 3'b010);
    pair(zbu_pkg::ZBU_OP_BRANCH_LT_ZERO_LINK_LIKELY, 5'h02, 32'h8000_0000, zbu_pkg::ZBU_OP_NONE,
         3'b101, 3'b100);
  endtask : s_likely
  // An idle gap keeps the slot pending; a flush or a reset drops it, and the branch re-runs.
  task automatic s_cancel();
    dec.put(zbu_pkg::ZBU_OP_BRANCH_LT_ZERO, 5'h02, 32'h8000_0000, 32'h0004_0000);
    dec.idle();
    chk("bp_update", bp_update_en, 32'h1);
    dec.put(zbu_pkg::ZBU_OP_NONE, 5'h03, 32'h0, 32'h0004_0004);
    dec.idle();
    chk("gap_redir_flag", {redirect.valid, delay_slot_flag}, 32'h3);
    dec.put(zbu_pkg::ZBU_OP_BRANCH_LT_ZERO, 5'h02, 32'h8000_0000, 32'h0004_0000);
    dec.idle();
    pipe_flush = 1'b1;
    dec.put(zbu_pkg::ZBU_OP_NONE, 5'h03, 32'h0, 32'h0004_0004);
    pipe_flush = 1'b0;
    dec.idle();
    chk("flush_redir_flag", {redirect.valid, delay_slot_flag}, 32'h0);
    dec.put(zbu_pkg::ZBU_OP_BRANCH_LT_ZERO, 5'h02, 32'h8000_0000, 32'h0004_0000);
    dec.idle();
    sys_rst = 1'b1;
    dec.idle();
    sys_rst = 1'b0;
    chk("reset_quiet", {link_wr.we, redirect.valid, bp_update_en}, 32'h0);
    dec.put(zbu_pkg::ZBU_OP_NONE, 5'h03, 32'h0, 32'h0004_0004);
    dec.idle();
    chk("reset_redir_flag", {redirect.valid, delay_slot_flag}, 32'h0);
    pair(zbu_pkg::ZBU_OP_BRANCH_LT_ZERO, 5'h02, 32'h8000_0000, zbu_pkg::ZBU_OP_NONE,
         3'b000, 3'b100);
  endtask : s_cancel
  task automatic s_newest();
    @(negedge clk);
    release6_mode = 1'b1;
    pair(zbu_pkg::ZBU_OP_BRANCH_LE_ZERO_LIKELY, 5'h02, 32'h0, zbu_pkg::ZBU_OP_NONE,
         3'b010, 3'b000);
    pair(zbu_pkg::ZBU_OP_BRANCH_LT_ZERO_LINK, 5'h02, 32'h8000_0000, zbu_pkg::ZBU_OP_NONE,
         3'b010, 3'b000);
    pair(zbu_pkg::ZBU_OP_BRANCH_LT_ZERO_LINK, 5'h00, 32'h1, zbu_pkg::ZBU_OP_NONE,
         3'b100, 3'b000);
    for (int k = 1; k < 14; k++) begin
      pair(zbu_pkg::ZBU_OP_BRANCH_LT_ZERO, 5'h02, 32'h1, zbu_pkg::zbu_op_t'(k[3:0]),
           3'b000, 3'b001);
    end
    @(negedge clk);
    release6_mode = 1'b0;
  endtask : s_newest
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // The full run needs about a hundred cycles, so this limit only catches a hang.
  initial begin
    repeat (2000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    s_link();
    s_conditions();
    s_likely();
    s_cancel();
    s_newest();
    end_of_test();
  end
endmodule : tb_zero_compare_branch_unit
`default_nettype wire
